// File: rtl/sbcfs_ptimer.v
`include "sbcfs_regs.vh"

module sbcfs_ptimer #(
    parameter CW = 15
) (
    input wire clk,
    input wire rst_n,
    input wire tick,
    input wire run_en,
    input wire wr,
    input wire [2:0] per_sel,
    input wire [2:0] on_sel,
    output reg hs_lvl,
    output reg on_end,
    output reg on_err
);
    localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

    reg [CW-1:0] per_ff;
    reg [CW-1:0] on_ff;
    reg [CW-1:0] cnt_ff;
    reg run_ff;

    function [CW-1:0] per_ticks;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: per_ticks = `SBCFS_PER_10MS;
                3'h1: per_ticks = `SBCFS_PER_20MS;
                3'h2: per_ticks = `SBCFS_PER_50MS;
                3'h3: per_ticks = `SBCFS_PER_100MS;
                3'h4: per_ticks = `SBCFS_PER_200MS;
                3'h5: per_ticks = `SBCFS_PER_1S;
                3'h6: per_ticks = `SBCFS_PER_2S;
                default: per_ticks = {CW{1'b0}};
            endcase
        end
    endfunction

    function [CW-1:0] on_ticks;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: on_ticks = `SBCFS_ON_0P1MS;
                3'h1: on_ticks = `SBCFS_ON_0P3MS;
                3'h2: on_ticks = `SBCFS_ON_1MS;
                3'h3: on_ticks = `SBCFS_ON_10MS;
                3'h4: on_ticks = `SBCFS_ON_20MS;
                default: on_ticks = {CW{1'b0}};
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (!rst_n) begin
            per_ff <= {CW{1'b0}};
            on_ff <= {CW{1'b0}};
            cnt_ff <= {CW{1'b0}};
            run_ff <= 1'b0;
            hs_lvl <= 1'b0;
            on_end <= 1'b0;
            on_err <= 1'b0;
        end else begin
            on_end <= 1'b0;
            on_err <= 1'b0;
            if (!run_en) begin
                run_ff <= 1'b0;
                hs_lvl <= 1'b0;
                cnt_ff <= {CW{1'b0}};
            end else if (wr) begin
                per_ff <= per_ticks(per_sel);
                on_ff <= on_ticks(on_sel);
                cnt_ff <= {CW{1'b0}};
                // Start on on-time write, off selections set idle level
                run_ff <= (on_ticks(on_sel) != {CW{1'b0}}) &&
                          (per_ticks(per_sel) != {CW{1'b0}});
                hs_lvl <= (on_ticks(on_sel) != {CW{1'b0}}) ||
                          (on_sel == `SBCFS_ON_OFF_HIGH);
                on_err <= on_ticks(on_sel) > per_ticks(per_sel);
            end else if (run_ff && tick) begin
                if (cnt_ff == on_ff - ONE) begin
                    hs_lvl <= 1'b0;
                    on_end <= 1'b1;
                end
                if (cnt_ff == per_ff - ONE) begin
                    cnt_ff <= {CW{1'b0}};
                    hs_lvl <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + ONE;
                end
            end
        end
    end
endmodule // sbcfs_ptimer

// File: rtl/sbcfs_regs.vh
`ifndef SBCFS_REGS_VH
`define SBCFS_REGS_VH

// Clock and derived timebase
`define SBCFS_CLK_KHZ 10000
`define SBCFS_TICK_NS 100000
`define SBCFS_TICK_CYC ((`SBCFS_TICK_NS * `SBCFS_CLK_KHZ) / 1000000)

// Wake filter time and cycles
`define SBCFS_FILT_NS 16000
`define SBCFS_FILT_CYC ((`SBCFS_FILT_NS * `SBCFS_CLK_KHZ) / 1000000)

// Fail-safe dwell and thermal restart delay
`define SBCFS_DWELL_MS 100
`define SBCFS_DWELL_TICKS ((`SBCFS_DWELL_MS * 1000000) / `SBCFS_TICK_NS)
`define SBCFS_THERMAL_SHUTDOWN_LEVEL_TWO_MS 1000
`define SBCFS_THERMAL_SHUTDOWN_LEVEL_TWO_TICKS ((`SBCFS_THERMAL_SHUTDOWN_LEVEL_TWO_MS * 1000000) / `SBCFS_TICK_NS)

// Debug strap high limit
`define SBCFS_STRAP_LIMIT_CYC 16

// Timer periods in ticks
`define SBCFS_PER_10MS 15'h0064
`define SBCFS_PER_20MS 15'h00C8
`define SBCFS_PER_50MS 15'h01F4
`define SBCFS_PER_100MS 15'h03E8
`define SBCFS_PER_200MS 15'h07D0
`define SBCFS_PER_1S 15'h2710
`define SBCFS_PER_2S 15'h4E20

// Timer on-times in ticks
`define SBCFS_ON_0P1MS 15'h0001
`define SBCFS_ON_0P3MS 15'h0003
`define SBCFS_ON_1MS 15'h000A
`define SBCFS_ON_10MS 15'h0064
`define SBCFS_ON_20MS 15'h00C8
`define SBCFS_ON_OFF_LOW 3'h5
`define SBCFS_ON_OFF_HIGH 3'h6

// Operating modes from the mode controller
`define SBCFS_MODE_INIT 2'h0
`define SBCFS_MODE_NORMAL 2'h1
`define SBCFS_MODE_STOP 2'h2
`define SBCFS_MODE_SLEEP 2'h3

// Status encodings
`define SBCFS_DEVST_NONE 2'h0
`define SBCFS_DEVST_FS 2'h1
`define SBCFS_WDERR_ONE 2'h1
`define SBCFS_WDERR_TWO 2'h2

`endif

// File: rtl/sbcfs_top.v
`include "sbcfs_regs.vh"

module sbcfs_top #(
    parameter TICK_CYC = `SBCFS_TICK_CYC,
    parameter DWELL_TICKS = `SBCFS_DWELL_TICKS,
    parameter THERMAL_SHUTDOWN_LEVEL_TWO_TICKS = `SBCFS_THERMAL_SHUTDOWN_LEVEL_TWO_TICKS,
    parameter STRAP_LIMIT = `SBCFS_STRAP_LIMIT_CYC
) (
    input wire SYS_CLK,
    input wire RST_N,
    input wire [1:0] MODE_IN,
    input wire THERMAL_SHUTDOWN_LEVEL_TWO,
    input wire PRIMARY_SHORT,
    input wire PRIMARY_OV,
    input wire PRIMARY_UV_EVENT,
    input wire BATTERY_UV,
    input wire WATCHDOG_ERROR_FIELD_EVENT,
    input wire WD_TRIGGER_OK,
    input wire SUPPLY_OVERVOLTAGE_RESET_ENABLE,
    input wire CONFIG_POLARITY_SELECT,
    input wire FAIL_COUNT_SELECT,
    input wire WAKE_MEASUREMENT_SELECT,
    input wire BUS_WAKE,
    input wire [2:0] WAKE_INPUTS,
    input wire DEBUG_STRAP_PIN,
    input wire SPI_ANY_CMD,
    input wire CONFIG_WRITE,
    input wire STATUS_CLEAR,
    input wire [2:0] WAKE_FLAGS_CLEAR,
    input wire FAULT_OUT_CLEAR,
    input wire SPI_ERR_CLEAR,
    input wire INT_ACK,
    input wire REG2_REQ,
    input wire REG3_REQ,
    input wire BUS_ON_REQ,
    input wire BUS_WAKE_CFG,
    input wire [2:0] WAKE_SRC_CFG,
    input wire [2:0] WAKE_CYCLIC_EN,
    input wire [2:0] WAKE_TIMER_SEL,
    input wire [1:0] HS_TIMER_MAP,
    input wire [1:0] HS_MANUAL,
    input wire TIMER_A_WR,
    input wire [2:0] TIMER_A_PERIOD,
    input wire [2:0] TIMER_A_ONTIME,
    input wire TIMER_B_WR,
    input wire [2:0] TIMER_B_PERIOD,
    input wire [2:0] TIMER_B_ONTIME,
    output reg FAILSAFE_ACTIVE,
    output reg RESTART_PULSE,
    output reg PRIMARY_REGULATOR_EN,
    output reg SECOND_REGULATOR_EN,
    output reg THIRD_REGULATOR_EN,
    output reg BUS_TRCV_ON,
    output reg BUS_WAKE_CAPABLE,
    output reg [2:0] WAKE_SOURCE_EN,
    output reg STATIC_SENSE_ONLY,
    output reg SPI_ENABLE,
    output reg [1:0] HIGH_SIDE_OUTPUTS,
    output reg [2:0] FAULT_OUTPUT_PINS,
    output reg DEVELOPMENT_MODE,
    output reg INT_N,
    output reg WAKE_REQ,
    output reg FAILURE_FLAG,
    output reg [1:0] DEVICE_STATUS_FIELD,
    output reg [1:0] WATCHDOG_ERROR_FIELD,
    output reg THERMAL_FLAG,
    output reg PRIMARY_UNDERVOLTAGE_FLAG,
    output reg REPEATED_UNDERVOLTAGE_FLAG,
    output reg PRIMARY_OVERVOLTAGE_FLAG,
    output reg PRIMARY_SHORT_FLAG,
    output reg SPI_ERROR_FLAG,
    output reg [2:0] WAKE_FLAGS_REGISTER_ONE,
    output reg [2:0] WAKE_LEVEL_SNAPSHOT
);
    localparam [1:0] ST_RUN = 2'h0;
    localparam [1:0] ST_FS = 2'h1;
    localparam [1:0] ST_RESTART = 2'h2;
    localparam [31:0] FILT_LAST = `SBCFS_FILT_CYC - 1;
    localparam [31:0] TICK_LAST = TICK_CYC - 1;
    localparam [31:0] DWELL_LAST = DWELL_TICKS - 1;
    localparam [31:0] THERMAL_SHUTDOWN_LEVEL_TWO_LAST = THERMAL_SHUTDOWN_LEVEL_TWO_TICKS - 1;
    localparam [31:0] STRAP_LAST = STRAP_LIMIT - 1;

    reg [1:0] st_ff;
    reg [15:0] tick_cnt_ff;
    reg tick_ff;
    reg [15:0] dwell_cnt_ff;
    reg dwell_done_ff;
    reg [15:0] tsd_cnt_ff;
    reg tsd_entry_ff;
    reg wake_pend_ff;
    reg [1:0] uv_cnt_ff;
    reg [1:0] wd_cnt_ff;
    reg [7:0] strap_cnt_ff;
    reg strap_bad_ff;
    reg dev_dflt_ff;

    wire fs = (st_ff == ST_FS);
    wire run = (st_ff == ST_RUN);
    wire norm_stop = (MODE_IN == `SBCFS_MODE_NORMAL) ||
                     (MODE_IN == `SBCFS_MODE_STOP);
    wire in_init = (MODE_IN == `SBCFS_MODE_INIT);

    // Entry causes
    wire uv_count = PRIMARY_UV_EVENT & ~BATTERY_UV;
    wire trg_tsd = THERMAL_SHUTDOWN_LEVEL_TWO;
    wire trg_sc = PRIMARY_SHORT;
    wire trg_ov = PRIMARY_OV & SUPPLY_OVERVOLTAGE_RESET_ENABLE &
                  ~CONFIG_POLARITY_SELECT;
    wire watchdog_error_field = WATCHDOG_ERROR_FIELD_EVENT & ~DEVELOPMENT_MODE;
    wire trg_wd = watchdog_error_field &
                  (FAIL_COUNT_SELECT | (wd_cnt_ff == 2'h1));
    wire trg_uv = uv_count & (uv_cnt_ff == 2'h3);
    wire fs_entry = run & (trg_tsd | trg_sc | trg_ov | trg_wd | trg_uv);
    wire wd_restart = run & watchdog_error_field & ~trg_wd;
    wire fs_exit = fs & ((dwell_done_ff & wake_pend_ff) |
                         (tsd_entry_ff & (tsd_cnt_ff == THERMAL_SHUTDOWN_LEVEL_TWO_LAST[15:0])));

    // Timers
    wire tmr_a_lvl;
    wire tmr_b_lvl;
    wire end_a;
    wire end_b;
    wire err_a;
    wire err_b;

    sbcfs_ptimer #(.CW(15)) u_tmr_a (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick_ff),
        .run_en(~fs),
        .wr(TIMER_A_WR),
        .per_sel(TIMER_A_PERIOD),
        .on_sel(TIMER_A_ONTIME),
        .hs_lvl(tmr_a_lvl),
        .on_end(end_a),
        .on_err(err_a)
    );

    sbcfs_ptimer #(.CW(15)) u_tmr_b (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick_ff),
        .run_en(~fs),
        .wr(TIMER_B_WR),
        .per_sel(TIMER_B_PERIOD),
        .on_sel(TIMER_B_ONTIME),
        .hs_lvl(tmr_b_lvl),
        .on_end(end_b),
        .on_err(err_b)
    );

    // Wake input sensing, static in fail-safe and cyclic otherwise for inputs with WAKE_CYCLIC_EN set
    wire [2:0] wk_ev;
    wire [2:0] wk_done;
    wire [2:0] wk_smp;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : wk
            reg [7:0] fc_ff;
            reg busy_ff;
            reg smp_ff;
            reg ref_ff;
            reg refok_ff;
            reg ev_ff;
            reg done_ff;
            wire src = (g == 2) | ~WAKE_MEASUREMENT_SELECT;
            wire ton_end = WAKE_TIMER_SEL[g] ? end_b : end_a;
            always @(posedge SYS_CLK) begin
                if (!RST_N) begin
                    fc_ff <= 8'h00;
                    busy_ff <= 1'b0;
                    smp_ff <= 1'b0;
                    ref_ff <= 1'b0;
                    refok_ff <= 1'b0;
                    ev_ff <= 1'b0;
                    done_ff <= 1'b0;
                end else begin
                    ev_ff <= 1'b0;
                    done_ff <= 1'b0;
                    if (fs) begin
                        busy_ff <= 1'b0;
                        refok_ff <= 1'b0;
                        if (WAKE_INPUTS[g] == ref_ff) begin
                            fc_ff <= 8'h00;
                        end else if (fc_ff == FILT_LAST[7:0]) begin
                            fc_ff <= 8'h00;
                            ref_ff <= WAKE_INPUTS[g];
                            ev_ff <= src;
                        end else begin
                            fc_ff <= fc_ff + 8'h01;
                        end
                    end else if (WAKE_CYCLIC_EN[g]) begin
                        if (ton_end) begin
                            busy_ff <= 1'b1;
                            smp_ff <= WAKE_INPUTS[g];
                            fc_ff <= 8'h00;
                        end else if (busy_ff) begin
                            if (WAKE_INPUTS[g] != smp_ff) begin
                                busy_ff <= 1'b0;
                            end else if (fc_ff == FILT_LAST[7:0]) begin
                                busy_ff <= 1'b0;
                                done_ff <= 1'b1;
                                refok_ff <= 1'b1;
                                ref_ff <= smp_ff;
                                ev_ff <= refok_ff &
                                         (smp_ff != ref_ff);
                            end else begin
                                fc_ff <= fc_ff + 8'h01;
                            end
                        end
                    end else begin
                        busy_ff <= 1'b0;
                        refok_ff <= 1'b0;
                        ref_ff <= WAKE_INPUTS[g];
                        fc_ff <= 8'h00;
                    end
                end
            end
            assign wk_ev[g] = ev_ff;
            assign wk_done[g] = done_ff;
            assign wk_smp[g] = smp_ff;
        end
    endgenerate

    // Tick divider
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (tick_cnt_ff == TICK_LAST[15:0]);
            if (tick_cnt_ff == TICK_LAST[15:0]) begin
                tick_cnt_ff <= 16'h0000;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 16'h0001;
            end
        end
    end

    // Mode state and fail-safe timing
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_ff <= ST_RUN;
            dwell_cnt_ff <= 16'h0000;
            dwell_done_ff <= 1'b0;
            tsd_cnt_ff <= 16'h0000;
            tsd_entry_ff <= 1'b0;
            wake_pend_ff <= 1'b0;
        end else begin
            case (st_ff)
                ST_RUN: begin
                    if (fs_entry) begin
                        st_ff <= ST_FS;
                        dwell_cnt_ff <= 16'h0000;
                        dwell_done_ff <= 1'b0;
                        tsd_cnt_ff <= 16'h0000;
                        tsd_entry_ff <= trg_tsd;
                        wake_pend_ff <= 1'b0;
                    end else if (wd_restart) begin
                        st_ff <= ST_RESTART;
                    end
                end
                ST_FS: begin
                    if (BUS_WAKE | (|wk_ev)) begin
                        wake_pend_ff <= 1'b1;
                    end
                    if (tick_ff && !dwell_done_ff) begin
                        dwell_done_ff <= (dwell_cnt_ff == DWELL_LAST[15:0]);
                        dwell_cnt_ff <= dwell_cnt_ff + 16'h0001;
                    end
                    if (tick_ff && tsd_entry_ff &&
                        tsd_cnt_ff != THERMAL_SHUTDOWN_LEVEL_TWO_LAST[15:0]) begin
                        tsd_cnt_ff <= tsd_cnt_ff + 16'h0001;
                    end
                    if (fs_exit) begin
                        st_ff <= ST_RESTART;
                    end
                end
                ST_RESTART: begin
                    st_ff <= ST_RUN;
                end
                default: begin
                    st_ff <= ST_RUN;
                end
            endcase
        end
    end

    // Failure counters and development mode
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            uv_cnt_ff <= 2'h0;
            wd_cnt_ff <= 2'h0;
            strap_cnt_ff <= 8'h00;
            strap_bad_ff <= 1'b0;
            DEVELOPMENT_MODE <= 1'b0;
            dev_dflt_ff <= 1'b0;
        end else begin
            if (fs_entry || (SPI_ANY_CMD && !uv_count)) begin
                uv_cnt_ff <= 2'h0;
            end else if (uv_count && run) begin
                uv_cnt_ff <= uv_cnt_ff + 2'h1;
            end
            if (fs_entry || WD_TRIGGER_OK) begin
                wd_cnt_ff <= 2'h0;
            end else if (watchdog_error_field && run && wd_cnt_ff != 2'h2) begin
                wd_cnt_ff <= wd_cnt_ff + 2'h1;
            end
            if (in_init && DEBUG_STRAP_PIN && !strap_bad_ff) begin
                strap_cnt_ff <= strap_cnt_ff + 8'h01;
                strap_bad_ff <= (strap_cnt_ff == STRAP_LAST[7:0]);
            end else if (!DEBUG_STRAP_PIN) begin
                strap_cnt_ff <= 8'h00;
            end
            if (in_init && SPI_ANY_CMD && !DEBUG_STRAP_PIN &&
                !strap_bad_ff) begin
                DEVELOPMENT_MODE <= 1'b1;
            end
            if (in_init && (DEVELOPMENT_MODE ||
                (!DEBUG_STRAP_PIN && !strap_bad_ff))) begin
                dev_dflt_ff <= 1'b1;
            end else if (CONFIG_WRITE || fs) begin
                dev_dflt_ff <= 1'b0;
            end
        end
    end

    // Status flags, set wins over clear except wake flags on entry
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            FAILURE_FLAG <= 1'b0;
            DEVICE_STATUS_FIELD <= `SBCFS_DEVST_NONE;
            WATCHDOG_ERROR_FIELD <= 2'h0;
            THERMAL_FLAG <= 1'b0;
            PRIMARY_UNDERVOLTAGE_FLAG <= 1'b0;
            REPEATED_UNDERVOLTAGE_FLAG <= 1'b0;
            PRIMARY_OVERVOLTAGE_FLAG <= 1'b0;
            PRIMARY_SHORT_FLAG <= 1'b0;
            SPI_ERROR_FLAG <= 1'b0;
            WAKE_FLAGS_REGISTER_ONE <= 3'h0;
            WAKE_LEVEL_SNAPSHOT <= 3'h0;
        end else begin
            FAILURE_FLAG <= fs_entry | (FAILURE_FLAG & ~STATUS_CLEAR);
            if (fs_entry) begin
                DEVICE_STATUS_FIELD <= `SBCFS_DEVST_FS;
            end else if (STATUS_CLEAR) begin
                DEVICE_STATUS_FIELD <= `SBCFS_DEVST_NONE;
            end
            if (watchdog_error_field && run) begin
                WATCHDOG_ERROR_FIELD <= (wd_cnt_ff == 2'h0) ?
                    `SBCFS_WDERR_ONE : `SBCFS_WDERR_TWO;
            end else if (STATUS_CLEAR) begin
                WATCHDOG_ERROR_FIELD <= 2'h0;
            end
            THERMAL_FLAG <= (fs_entry & trg_tsd) |
                            (THERMAL_FLAG & ~STATUS_CLEAR);
            PRIMARY_UNDERVOLTAGE_FLAG <= PRIMARY_UV_EVENT |
                (fs_entry & trg_sc) |
                (PRIMARY_UNDERVOLTAGE_FLAG & ~STATUS_CLEAR);
            REPEATED_UNDERVOLTAGE_FLAG <= (fs_entry & trg_uv) |
                (REPEATED_UNDERVOLTAGE_FLAG & ~STATUS_CLEAR);
            PRIMARY_OVERVOLTAGE_FLAG <= (fs_entry & trg_ov) |
                (PRIMARY_OVERVOLTAGE_FLAG & ~STATUS_CLEAR);
            PRIMARY_SHORT_FLAG <= (fs_entry & trg_sc) |
                (PRIMARY_SHORT_FLAG & ~STATUS_CLEAR);
            SPI_ERROR_FLAG <= err_a | err_b |
                (SPI_ERROR_FLAG & ~SPI_ERR_CLEAR);
            if (fs_entry) begin
                WAKE_FLAGS_REGISTER_ONE <= 3'h0;
            end else begin
                WAKE_FLAGS_REGISTER_ONE <= wk_ev |
                    (WAKE_FLAGS_REGISTER_ONE & ~WAKE_FLAGS_CLEAR);
            end
            if (norm_stop && !fs) begin
                WAKE_LEVEL_SNAPSHOT <= (wk_done & wk_smp) |
                    (~wk_done & WAKE_LEVEL_SNAPSHOT);
            end
        end
    end

    // Outputs
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            FAILSAFE_ACTIVE <= 1'b0;
            RESTART_PULSE <= 1'b0;
            PRIMARY_REGULATOR_EN <= 1'b0;
            SECOND_REGULATOR_EN <= 1'b0;
            THIRD_REGULATOR_EN <= 1'b0;
            BUS_TRCV_ON <= 1'b0;
            BUS_WAKE_CAPABLE <= 1'b0;
            WAKE_SOURCE_EN <= 3'h0;
            STATIC_SENSE_ONLY <= 1'b0;
            SPI_ENABLE <= 1'b0;
            HIGH_SIDE_OUTPUTS <= 2'h0;
            FAULT_OUTPUT_PINS <= 3'h0;
            INT_N <= 1'b1;
            WAKE_REQ <= 1'b0;
        end else begin
            FAILSAFE_ACTIVE <= fs;
            RESTART_PULSE <= (st_ff == ST_RESTART);
            PRIMARY_REGULATOR_EN <= run &&
                (MODE_IN != `SBCFS_MODE_SLEEP);
            SECOND_REGULATOR_EN <= run &
                (REG2_REQ | dev_dflt_ff);
            THIRD_REGULATOR_EN <= run & REG3_REQ;
            BUS_TRCV_ON <= run & (BUS_ON_REQ | dev_dflt_ff);
            BUS_WAKE_CAPABLE <= fs | BUS_WAKE_CFG;
            WAKE_SOURCE_EN <= fs ? {1'b1, {2{~WAKE_MEASUREMENT_SELECT}}}
                                 : WAKE_SRC_CFG;
            STATIC_SENSE_ONLY <= fs;
            SPI_ENABLE <= run;
            HIGH_SIDE_OUTPUTS[0] <= run &
                (HS_TIMER_MAP[0] ? tmr_a_lvl : HS_MANUAL[0]);
            HIGH_SIDE_OUTPUTS[1] <= run &
                (HS_TIMER_MAP[1] ? tmr_b_lvl : HS_MANUAL[1]);
            if (fs_entry) begin
                FAULT_OUTPUT_PINS <= 3'h7;
            end else if (FAULT_OUT_CLEAR && !fs) begin
                FAULT_OUTPUT_PINS <= 3'h0;
            end
            if ((|wk_ev) && !fs && norm_stop) begin
                INT_N <= 1'b0;
            end else if (INT_ACK) begin
                INT_N <= 1'b1;
            end
            WAKE_REQ <= (|wk_ev) && !fs &&
                (MODE_IN == `SBCFS_MODE_SLEEP);
        end
    end
endmodule // sbcfs_top

// File: tb/sbcfs_host.sv
module sbcfs_host #(
    parameter int LAT = 4
) (
    input wire logic clk,
    input wire logic int_n,
    output logic int_ack = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    // Acknowledge a raised interrupt after a delay
    always @(posedge clk) begin
        n <= int_n ? 0 : n + 1;
        int_ack <= !int_n && n == LAT;
    end
endmodule // sbcfs_host

// File: tb/sbcfs_monitor.sv
module sbcfs_monitor (
    input wire SYS_CLK,
    input wire RST_N,
    input wire PRIMARY_SHORT,
    input wire THERMAL_SHUTDOWN_LEVEL_TWO,
    input wire WAKE_MEASUREMENT_SELECT,
    input wire FAILSAFE_ACTIVE,
    input wire RESTART_PULSE,
    input wire PRIMARY_REGULATOR_EN,
    input wire SPI_ENABLE,
    input wire [1:0] HIGH_SIDE_OUTPUTS,
    input wire [2:0] WAKE_SOURCE_EN,
    input wire [2:0] FAULT_OUTPUT_PINS,
    input wire FAILURE_FLAG,
    input wire [1:0] DEVICE_STATUS_FIELD,
    input wire DEVELOPMENT_MODE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    AST_SHORT: assert property (PRIMARY_SHORT && !FAILSAFE_ACTIVE &&
        !RESTART_PULSE |-> ##[1:3] FAILSAFE_ACTIVE) else $error("short");
    AST_THERMAL: assert property (THERMAL_SHUTDOWN_LEVEL_TWO &&
        !FAILSAFE_ACTIVE && !RESTART_PULSE |-> ##[1:3] FAILSAFE_ACTIVE)
        else $error("thermal");
    AST_OFF: assert property ($rose(FAILSAFE_ACTIVE) |->
        (!PRIMARY_REGULATOR_EN && !SPI_ENABLE && HIGH_SIDE_OUTPUTS == 2'h0)
        [*8]) else $error("supplies on");
    AST_WAKE: assert property ($rose(FAILSAFE_ACTIVE) |->
        WAKE_SOURCE_EN == {1'h1, {2{!WAKE_MEASUREMENT_SELECT}}})
        else $error("wake sources");
    AST_FAULT: assert property (
        FAILSAFE_ACTIVE || $fell(FAILSAFE_ACTIVE) |->
        FAULT_OUTPUT_PINS == 3'h7) else $error("fault pins");
    AST_STATUS: assert property ($rose(FAILSAFE_ACTIVE) |->
        FAILURE_FLAG && DEVICE_STATUS_FIELD == 2'h1) else $error("status");
    AST_DWELL: assert property ($rose(FAILSAFE_ACTIVE) |->
        !RESTART_PULSE throughout (##30 1'h1)) else $error("dwell");
    AST_DEV: assert property (DEVELOPMENT_MODE |=> DEVELOPMENT_MODE)
        else $error("dev mode lost");
endmodule // sbcfs_monitor
bind sbcfs_top sbcfs_monitor sbcfs_monitor_i (.*);

// File: tb/test_sbc_failsafe_cyclic_sense.sv
module test_sbc_failsafe_cyclic_sense;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK, RST_N, CONFIG_POLARITY_SELECT, FAIL_COUNT_SELECT;
    logic BATTERY_UV, DEBUG_STRAP_PIN;
    logic [1:0] MODE_IN, HS_TIMER_MAP;
    logic [2:0] WAKE_INPUTS, WAKE_CYCLIC_EN, TIMER_A_PERIOD, TIMER_A_ONTIME;
    logic [8:0] ev;
    logic [31:0] seed;
    logic [14:0] q[$];
    int n_errors = 0, samples_checked = 0, cnt, cyc_n = 0;
    wire INT_ACK, FAILSAFE_ACTIVE, RESTART_PULSE, PRIMARY_REGULATOR_EN;
    wire SECOND_REGULATOR_EN, THIRD_REGULATOR_EN, BUS_TRCV_ON, INT_N, WAKE_REQ;
    wire BUS_WAKE_CAPABLE, STATIC_SENSE_ONLY, SPI_ENABLE, DEVELOPMENT_MODE;
    wire FAILURE_FLAG, THERMAL_FLAG, PRIMARY_UNDERVOLTAGE_FLAG, SPI_ERROR_FLAG;
    wire REPEATED_UNDERVOLTAGE_FLAG, PRIMARY_OVERVOLTAGE_FLAG, PRIMARY_SHORT_FLAG;
    wire [1:0] HIGH_SIDE_OUTPUTS, DEVICE_STATUS_FIELD, WATCHDOG_ERROR_FIELD;
    wire [2:0] WAKE_SOURCE_EN, FAULT_OUTPUT_PINS, WAKE_FLAGS_REGISTER_ONE;
    wire [2:0] WAKE_LEVEL_SNAPSHOT;
    wire [3:0] sig = {WAKE_REQ, ~INT_N, RESTART_PULSE, FAILSAFE_ACTIVE};
    sbcfs_top #(.TICK_CYC(10), .DWELL_TICKS(5), .THERMAL_SHUTDOWN_LEVEL_TWO_TICKS(20)) sbcfs_top_i (
        .*, .THERMAL_SHUTDOWN_LEVEL_TWO(ev[0]), .PRIMARY_SHORT(ev[1]),
        .PRIMARY_OV(ev[2]), .PRIMARY_UV_EVENT(ev[3]), .WATCHDOG_ERROR_FIELD_EVENT(ev[4]),
        .BUS_WAKE(ev[5]), .SPI_ANY_CMD(ev[6]), .STATUS_CLEAR(ev[7]),
        .FAULT_OUT_CLEAR(ev[7]), .SPI_ERR_CLEAR(ev[7]), .TIMER_A_WR(ev[8]),
        .WAKE_FLAGS_CLEAR({3{ev[7]}}), .WD_TRIGGER_OK(ev[7]), .TIMER_B_WR(ev[8]),
        .SUPPLY_OVERVOLTAGE_RESET_ENABLE(1'h1), .WAKE_TIMER_SEL(3'h0),
        .REG2_REQ(seed[0]), .REG3_REQ(seed[1]), .BUS_ON_REQ(seed[2]),
        .BUS_WAKE_CFG(seed[3]), .WAKE_SRC_CFG(seed[6:4]), .HS_MANUAL(seed[8:7]),
        .CONFIG_WRITE(seed[9]), .TIMER_B_PERIOD(seed[12:10]),
        .TIMER_B_ONTIME(seed[15:13]), .WAKE_MEASUREMENT_SELECT(seed[16]));
    sbcfs_host sbcfs_host_i (.clk(SYS_CLK), .int_n(INT_N), .int_ack(INT_ACK));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task pul(input logic [8:0] m);
        @(posedge SYS_CLK) ev <= m;
        @(posedge SYS_CLK) ev <= 9'h000;
    endtask
    task wt(input int s);
        cnt = 0;
        do @(posedge SYS_CLK); while (sig[s] !== 1'h1 && ++cnt < 3000);
        check(sig[s], 1'h1);
    endtask
    initial begin
        SYS_CLK = 1'h0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) if (++cyc_n > 20000) begin
        n_errors++;
        print_verdict;
    end
    // Entry flags compared when fail-safe shows
    always @(posedge FAILSAFE_ACTIVE) begin
        #1;
        check({THERMAL_FLAG, PRIMARY_SHORT_FLAG, PRIMARY_OVERVOLTAGE_FLAG,
            REPEATED_UNDERVOLTAGE_FLAG, WATCHDOG_ERROR_FIELD, FAILURE_FLAG,
            DEVICE_STATUS_FIELD, FAULT_OUTPUT_PINS, WAKE_FLAGS_REGISTER_ONE},
            q.size() ? q.pop_front() : 15'h7FFF);
        check({BUS_WAKE_CAPABLE, STATIC_SENSE_ONLY, THIRD_REGULATOR_EN,
            SECOND_REGULATOR_EN}, 4'hC);
    end
    initial begin
        {RST_N, ev, MODE_IN, DEBUG_STRAP_PIN, CONFIG_POLARITY_SELECT, BATTERY_UV,
            FAIL_COUNT_SELECT, WAKE_CYCLIC_EN, HS_TIMER_MAP, TIMER_A_PERIOD,
            TIMER_A_ONTIME} = '0;
        seed = lfsr(32'hDDBB94BC);
        WAKE_INPUTS = seed[19:17];
        repeat (6) @(posedge SYS_CLK);
        RST_N <= 1'h1;
        pul(9'h040);
        repeat (2) @(posedge SYS_CLK);
        check({DEVELOPMENT_MODE, SECOND_REGULATOR_EN, BUS_TRCV_ON}, 3'h7);
        MODE_IN <= 2'h1;
        FAIL_COUNT_SELECT <= 1'h1;
        pul(9'h010);
        repeat (8) @(posedge SYS_CLK);
        check(FAILSAFE_ACTIVE, 1'h0);
        RST_N <= 1'h0;
        DEBUG_STRAP_PIN <= 1'h1;
        MODE_IN <= 2'h0;
        repeat (6) @(posedge SYS_CLK);
        RST_N <= 1'h1;
        repeat (30) @(posedge SYS_CLK);
        DEBUG_STRAP_PIN <= 1'h0;
        pul(9'h040);
        repeat (2) @(posedge SYS_CLK);
        check(DEVELOPMENT_MODE, 1'h0);
        MODE_IN <= 2'h1;
        $display("development test done");
        for (int k = 0; k < 5; k++) begin
            pul(9'h080);
            q.push_back({k == 0, k == 1, k == 2, k == 4, k == 3 ? 2'h1 : 2'h0,
                9'h178});
            if (k == 4) begin
                BATTERY_UV <= 1'h1;
                pul(9'h008);
                BATTERY_UV <= 1'h0;
                repeat (3) pul(9'h008);
            end
            pul(k == 4 ? 9'h008 : k == 3 ? 9'h010 : 9'h001 << k);
            wt(0);
            pul(k ? 9'h020 : 9'h000);
            wt(1);
            check(cnt >= (k ? 35 : 180) && cnt <= (k ? 65 : 220), 1'h1);
            repeat (20) @(posedge SYS_CLK);
            $display("fault %0d done", k);
        end
        HS_TIMER_MAP <= 2'h1;
        WAKE_CYCLIC_EN <= 3'h4;
        TIMER_A_ONTIME <= 3'h4;
        pul(9'h100);
        repeat (3) @(posedge SYS_CLK);
        check({SPI_ERROR_FLAG, HIGH_SIDE_OUTPUTS},
            {1'h1, seed[8], 1'h1});
        TIMER_A_ONTIME <= 3'h0;
        pul(9'h100);
        repeat (1500) @(posedge SYS_CLK);
        check(INT_N, 1'h1);
        WAKE_INPUTS[2] <= ~WAKE_INPUTS[2];
        wt(2);
        check({WAKE_FLAGS_REGISTER_ONE[2], WAKE_LEVEL_SNAPSHOT[2]},
            {1'h1, WAKE_INPUTS[2]});
        MODE_IN <= 2'h3;
        WAKE_INPUTS[2] <= ~WAKE_INPUTS[2];
        wt(3);
        check({INT_N, WAKE_LEVEL_SNAPSHOT[2]},
            {1'h1, !WAKE_INPUTS[2]});
        $display("cyclic sense done");
        print_verdict;
    end
endmodule // test_sbc_failsafe_cyclic_sense
